/* File: rtl/emb_pkg.sv */
package emb_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int PIN_ADDR_W = 12;
  // Bank windows, 256 KB each
  localparam logic [23:0] BANK0_BASE = 24'h000000;
  localparam logic [23:0] BANK0_LAST = 24'h03FFFF;
  localparam logic [23:0] BANK1_BASE = 24'h800000;
  localparam logic [23:0] BANK1_LAST = 24'h83FFFF;
  localparam logic [23:0] BANK2_BASE = 24'hC00000;
  localparam logic [23:0] BANK2_LAST = 24'hC3FFFF;
  // Boot mode pin encodings
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_EXT_ROM = 2'h1;
  localparam logic [1:0] MODE_EXT_ICE = 2'h2;
  localparam logic [1:0] MODE_FLASH_TEST = 2'h3;
  // Reset values
  localparam logic [2:0] SEL_IDLE = 3'h7;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [1:0] {
    EMB_IDLE = 2'b00,
    EMB_ACCESS = 2'b01,
    EMB_DONE = 2'b10
  } emb_state_e;
endpackage

/* File: rtl/emb_decode_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface emb_decode_if;
  logic [23:0] addr;
  logic [1:0] boot_mode;
  logic [2:0] sel_n;
  logic hit;
  modport requester (output addr, output boot_mode, input sel_n, input hit);
  modport decoder (input addr, input boot_mode, output sel_n, output hit);
endinterface
`default_nettype wire

/* File: rtl/emb_bank_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_bank_decode (
  emb_decode_if.decoder dec // Address in, selects out
);
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
  wire ext_rom = (dec.boot_mode == emb_pkg::MODE_EXT_ROM) ||
                 (dec.boot_mode == emb_pkg::MODE_EXT_ICE);
  wire hit0 = ext_rom && in_range(dec.addr, emb_pkg::BANK0_BASE, emb_pkg::BANK0_LAST);
  wire hit1 = in_range(dec.addr, emb_pkg::BANK1_BASE, emb_pkg::BANK1_LAST);
  wire hit2 = in_range(dec.addr, emb_pkg::BANK2_BASE, emb_pkg::BANK2_LAST);
  // Windows are disjoint, so at most one select is low
  assign dec.sel_n = ~{hit2, hit1, hit0};
  assign dec.hit = hit0 | hit1 | hit2;
endmodule // emb_bank_decode
`default_nettype wire

/* File: rtl/emb_bus_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl (
  input wire logic i_ref_clk, // 100 MHz clock
  input wire logic i_reset, // Synchronous, active high
  input wire logic i_req, // Start access (level, taken when idle)
  input wire logic i_write, // 1 write, 0 read
  input wire logic [23:0] i_addr, // Byte address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [1:0] i_boot_mode_pins, // Boot mode straps
  output logic o_busy, // Access in progress
  output logic o_done, // One-cycle completion pulse
  output logic [7:0] o_rdata, // Read data, valid with o_done for mapped reads; unmapped reads leave it unchanged
  output logic o_boot_from_bank0, // Boot source is bank zero
  output logic [11:0] o_addr_pins, // Address lines 11..0
  output logic o_write_strobe_n, // Write strobe, active low
  output logic o_read_strobe_n, // Read strobe, active low
  output logic o_bank0_select_n, // Bank 0 select
  output logic o_bank1_select_n, // Bank 1 select
  output logic o_bank2_select_n, // Bank 2 select
  input wire logic i_wait_request_n, // Memory stretch request, active low
  input wire logic [7:0] i_data_pins, // Data bus input
  output logic [7:0] o_data_pins, // Data bus output
  output logic o_data_oe // Data bus drive enable
);
  emb_pkg::emb_state_e state_q;
  emb_pkg::emb_state_e state_d;
  logic write_q;
  logic [7:0] rdata_q;
  logic [7:0] wdata_q;
  logic [11:0] addr_q;
  logic [2:0] sel_n_q;
  logic boot_q;
  logic done_q;
  logic we_n_q;
  logic oe_n_q;
  logic doe_q;
  logic busy_q;
  emb_decode_if dec_bus ();
  emb_bank_decode u_decode (.dec(dec_bus));
  assign dec_bus.addr = i_addr;
  assign dec_bus.boot_mode = i_boot_mode_pins;

  // Done cycle still counts as busy, so a held request waits for it
  wire start = (state_q == emb_pkg::EMB_IDLE) && i_req && !done_q;
  // Unmapped addresses finish at once with no pin activity
  wire start_ext = start && dec_bus.hit;
  wire start_miss = start && !dec_bus.hit;
  wire in_access = state_q == emb_pkg::EMB_ACCESS;
  wire finish = in_access && i_wait_request_n;
  wire hold_write = in_access && write_q && !finish;
  wire hold_read = in_access && !write_q && !finish;
  wire we_n_d = !((start_ext && i_write) || hold_write);
  wire oe_n_d = !((start_ext && !i_write) || hold_read);
  wire doe_d = (start_ext && i_write) || hold_write;
  wire done_d = finish || start_miss;
  wire busy_d = (state_d != emb_pkg::EMB_IDLE) || done_d;
  wire boot_d = (i_boot_mode_pins == emb_pkg::MODE_EXT_ROM) ||
                (i_boot_mode_pins == emb_pkg::MODE_EXT_ICE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      emb_pkg::EMB_IDLE: begin
        if (start_ext) begin
          state_d = emb_pkg::EMB_ACCESS;
        end
      end
      emb_pkg::EMB_ACCESS: begin
        if (finish) begin
          state_d = emb_pkg::EMB_DONE;
        end
      end
      emb_pkg::EMB_DONE: begin
        state_d = emb_pkg::EMB_IDLE;
      end
      default: begin
        state_d = emb_pkg::EMB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= emb_pkg::EMB_IDLE;
      boot_q <= 1'b0;
    end else begin
      state_q <= state_d;
      boot_q <= boot_d;
    end
  end

  // Request fields are captured once and stand until the completing edge
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      write_q <= 1'b0;
      addr_q <= emb_pkg::ADDR_RST;
      wdata_q <= emb_pkg::DATA_RST;
    end else if (start_ext) begin
      write_q <= i_write;
      addr_q <= i_addr[11:0];
      wdata_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sel_n_q <= emb_pkg::SEL_IDLE;
    end else if (start_ext) begin
      sel_n_q <= dec_bus.sel_n;
    end else if (finish) begin
      sel_n_q <= emb_pkg::SEL_IDLE;
    end
  end

  // Taken on the completing edge, once the memory has let go of wait
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rdata_q <= emb_pkg::DATA_RST;
    end else if (finish && !write_q) begin
      rdata_q <= i_data_pins;
    end
  end

  // Registered so no decode glitch reaches the memory pins
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q <= 1'b0;
    end else begin
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      doe_q <= doe_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rdata = rdata_q;
  assign o_boot_from_bank0 = boot_q;
  assign o_addr_pins = addr_q;
  assign o_write_strobe_n = we_n_q;
  assign o_read_strobe_n = oe_n_q;
  assign o_bank0_select_n = sel_n_q[0];
  assign o_bank1_select_n = sel_n_q[1];
  assign o_bank2_select_n = sel_n_q[2];
  assign o_data_pins = wdata_q;
  assign o_data_oe = doe_q;

  // Strobe and select checks
  chk_one_select: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $countones(~sel_n_q) <= 1) else $error("more than one bank select");
  chk_write_strobe_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !we_n_q |-> (sel_n_q != emb_pkg::SEL_IDLE) && write_q) else $error("stray write strobe");
  chk_read_strobe_sel: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !oe_n_q |-> (sel_n_q != emb_pkg::SEL_IDLE) && !write_q) else $error("stray read strobe");
  chk_strobe_exclusive: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    we_n_q || oe_n_q) else $error("both strobes low");

  // Wait stretch checks
  chk_wait_holds: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    in_access && !i_wait_request_n |=> state_q == emb_pkg::EMB_ACCESS)
    else $error("cycle ended under wait");
  chk_select_stands: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    in_access && !i_wait_request_n |=> $stable(sel_n_q) && $stable(addr_q) &&
    $stable(we_n_q) && $stable(oe_n_q)) else $error("pins moved under wait");
  chk_wait_release: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    in_access && i_wait_request_n |=> sel_n_q == emb_pkg::SEL_IDLE && we_n_q && oe_n_q &&
    !doe_q) else $error("cycle not closed after wait");
  chk_done_follows: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    finish |=> done_q) else $error("no done after completion");
  chk_busy_covers: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    in_access |-> busy_q) else $error("busy low during access");

  // Bank decode checks
  chk_bank0_mode: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext && !dec_bus.sel_n[0] |-> boot_d && i_addr <= emb_pkg::BANK0_LAST)
    else $error("bank0 select outside rom mode");
  chk_bank0_off: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext && !boot_d |=> sel_n_q[0]) else $error("bank0 select in internal mode");
  chk_bank1_range: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext && i_addr >= emb_pkg::BANK1_BASE && i_addr <= emb_pkg::BANK1_LAST
    |=> !sel_n_q[1]) else $error("bank1 select missing");
  chk_bank2_range: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext && i_addr >= emb_pkg::BANK2_BASE && i_addr <= emb_pkg::BANK2_LAST
    |=> !sel_n_q[2]) else $error("bank2 select missing");
  chk_unmapped_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_miss |=> sel_n_q == emb_pkg::SEL_IDLE && we_n_q && oe_n_q && !doe_q)
    else $error("pin activity on unmapped access");

  // Data, address and boot checks
  chk_data_drive: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    doe_q |-> !we_n_q && oe_n_q) else $error("data driven outside write");
  chk_write_data: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext && i_write |=> doe_q && o_data_pins == $past(i_wdata))
    else $error("write data not on bus");
  chk_read_sample: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    finish && !write_q |=> o_rdata == $past(i_data_pins)) else $error("read data not taken");
  chk_addr_pins: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    start_ext |=> o_addr_pins == $past(i_addr[11:0])) else $error("address pins wrong");
  chk_boot_flag: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    1'b1 |=> o_boot_from_bank0 == ($past(i_boot_mode_pins) == emb_pkg::MODE_EXT_ROM ||
    $past(i_boot_mode_pins) == emb_pkg::MODE_EXT_ICE)) else $error("boot source flag wrong");
endmodule // emb_bus_ctrl
`default_nettype wire

/* File: dv/emb_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input wire logic i_clk, // Bus clock
  input wire logic [2:0] i_sel_n, // Bank selects
  input wire logic i_rd_n, // Read strobe
  input wire logic i_wr_n, // Write strobe
  input wire logic [11:0] i_addr, // Address lines
  input wire logic [7:0] i_wdata, // Data from controller
  input wire logic [1:0] i_stall, // Wait cycles per access
  output logic [7:0] o_rdata, // Data to bus
  output logic o_drive, // Model drives bus
  output logic o_wait_n // Stretch request
);
  logic [7:0] mem [0:16383];
  logic [1:0] cnt_q;
  logic [13:0] idx;
  logic act;
  assign act = i_sel_n != 3'h7;
  assign idx = {(i_sel_n[0] ? (i_sel_n[1] ? 2'h2 : 2'h1) : 2'h0), i_addr};
  assign o_wait_n = !(act && cnt_q < i_stall);
  assign o_drive = !i_rd_n && act;
  assign o_rdata = mem[idx];
  initial for (int k = 0; k < 16384; k++) mem[k] = 8'h00;
  always @(posedge i_clk) begin
    cnt_q <= act ? cnt_q + {1'b0, cnt_q < i_stall} : 2'h0;
    if (!i_wr_n && act && o_wait_n) mem[idx] <= i_wdata;
  end
endmodule // emb_mem_model
`default_nettype wire

/* File: dv/external_memory_bank_bus_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); num_errors++; end end
module external_memory_bank_bus_bench;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, busy, done, boot, we_n, re_n, oe;
  logic drv, wt_n;
  logic [1:0] mode = 2'h0, stall = 2'h0;
  wire [2:0] sel_n;
  logic [23:0] addr = 24'h000000;
  logic [7:0] wd = 8'h00, rd, dout, mdat, bus;
  logic [11:0] apin;
  logic [7:0] shadow [logic [13:0]];
  int num_errors = 0, compares = 0;
  integer seed = 32'hF4009DBA;
  logic [7:0] tops [10] = '{8'h00, 8'h03, 8'h04, 8'h80, 8'h83, 8'h84, 8'hC0, 8'hC3, 8'hC4, 8'h7F};
  always #5 clk = ~clk;
  // Released bus reads low through the pull-downs
  assign bus = oe ? dout : (drv ? mdat : 8'h00);
  emb_bus_ctrl u_dut (.i_ref_clk(clk), .i_reset(rst), .i_req(req), .i_write(wr), .i_addr(addr),
    .i_wdata(wd), .i_boot_mode_pins(mode), .o_busy(busy), .o_done(done), .o_rdata(rd),
    .o_boot_from_bank0(boot), .o_addr_pins(apin), .o_write_strobe_n(we_n),
    .o_read_strobe_n(re_n), .o_bank0_select_n(sel_n[0]), .o_bank1_select_n(sel_n[1]),
    .o_bank2_select_n(sel_n[2]), .i_wait_request_n(wt_n), .i_data_pins(bus),
    .o_data_pins(dout), .o_data_oe(oe));
  emb_mem_model u_mem (.i_clk(clk), .i_sel_n(sel_n), .i_rd_n(re_n), .i_wr_n(we_n),
    .i_addr(apin), .i_wdata(dout), .i_stall(stall), .o_rdata(mdat), .o_drive(drv),
    .o_wait_n(wt_n));
  function automatic logic [2:0] exp_sel(input logic [23:0] a, input logic [1:0] m);
    return {~(a >= 24'hC00000 && a <= 24'hC3FFFF), ~(a >= 24'h800000 && a <= 24'h83FFFF),
      ~(a <= 24'h03FFFF && (m == 2'h1 || m == 2'h2))};
  endfunction
  task automatic access(input logic w, input logic [23:0] a, input logic [7:0] d,
      input logic [1:0] m, input logic [1:0] st);
    logic [2:0] es;
    logic [13:0] k;
    int n;
    es = exp_sel(a, m);
    k = {(es[0] ? (es[1] ? 2'h2 : 2'h1) : 2'h0), a[11:0]};
    mode = m;
    stall = st;
    @(posedge clk) #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(posedge clk) #1;
    req = 1'b0;
    `CHK("busy", 1'b1, busy)
    `CHK("boot", m == 2'h1 || m == 2'h2, boot)
    if (es != 3'h7) begin
      `CHK("sel", es, sel_n)
      `CHK("strobes", {w, !w, w}, {re_n, we_n, oe})
      `CHK("apin", a[11:0], apin)
      if (w) `CHK("dout", d, dout)
    end
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK("latency", (es != 3'h7) ? 1 + st : 0, n)
    `CHK("idle", 6'h3E, {sel_n, we_n, re_n, oe})
    if (es != 3'h7 && w) shadow[k] = d;
    if (es != 3'h7 && !w) `CHK("rdata", shadow.exists(k) ? shadow[k] : 8'h00, rd)
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    `CHK("reset", 8'hF8, {sel_n, we_n, re_n, oe, busy, done})
    access(1'b1, 24'h83FFFF, 8'hA5, 2'h0, 2'h3);
    access(1'b0, 24'h83FFFF, 8'h00, 2'h0, 2'h0);
    access(1'b1, 24'h03FFFF, 8'h3C, 2'h1, 2'h1);
    access(1'b0, 24'h03FFFF, 8'h00, 2'h2, 2'h2);
    access(1'b0, 24'h03FFFF, 8'h00, 2'h0, 2'h0);
    access(1'b1, 24'h040000, 8'h11, 2'h1, 2'h0);
    access(1'b0, 24'hC00000, 8'h00, 2'h3, 2'h1);
    repeat (200) access(1'($random(seed)), {tops[$unsigned($random(seed)) % 10],
      16'($random(seed))}, 8'($random(seed)), 2'($random(seed)), 2'($random(seed)));
    end_of_test;
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule // external_memory_bank_bus_bench
`default_nettype wire
